// [hw/ocd_pkg.sv]
// Package with register map, field layout, reset values and types for clock control
package ocd_pkg;

    // Byte addresses of the APB register words
    localparam logic [7:0] ADDR_OSC_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CLK_DIV    = 8'h04;
    localparam logic [7:0] ADDR_PLL_FBD    = 8'h08;
    localparam logic [7:0] ADDR_RC_TRIM    = 8'h0c;
    localparam logic [7:0] ADDR_UNLOCK     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;

    // Unlock keys, values arbitrary
    localparam logic [15:0] UNLOCK_KEY1 = 16'h005a;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h00a5;

    // Oscillator control fields
    localparam int OSC_CUR_LSB  = 12;
    localparam int OSC_NEW_LSB  = 8;
    localparam int OSC_CF_BIT   = 3;
    localparam int OSC_SEC_BIT  = 1;
    localparam int OSC_SW_BIT   = 0;

    // Clock divisor fields
    localparam int DIV_ROI_BIT  = 15;
    localparam int DIV_DOZE_LSB = 12;
    localparam int DIV_DZEN_BIT = 11;
    localparam int DIV_FRC_LSB  = 8;
    localparam int DIV_POST_LSB = 6;
    localparam int DIV_PRE_LSB  = 0;

    // Reset values
    localparam logic [2:0] RST_DOZE  = 3'h3;
    localparam logic [1:0] RST_POST  = 2'h1;
    localparam logic [8:0] RST_MULT  = 9'h030;
    localparam logic [2:0] RST_SRC   = 3'h0;

    // Source codes
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;

    // Postscaler codes
    localparam logic [1:0] POST_DIV2 = 2'h0;
    localparam logic [1:0] POST_DIV4 = 2'h1;
    localparam logic [1:0] POST_DIV8 = 2'h3;

    // Offsets added to prescaler and feedback codes
    localparam logic [5:0] PRE_OFFSET  = 6'h02;
    localparam logic [9:0] MULT_OFFSET = 10'h002;

    // Interrupt status bits
    localparam int IRQ_FAIL_BIT  = 0;
    localparam int IRQ_DONE_BIT  = 1;
    localparam int IRQ_ABORT_BIT = 2;
    localparam int IRQ_W         = 3;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT
    } ocd_sw_e;

    typedef struct packed {
        logic [2:0] periph_log2;
        logic [2:0] rc_post_log2;
        logic [3:0] post_div;
        logic [5:0] pre_div;
        logic [9:0] mult;
        logic [5:0] rc_trim;
    } ocd_clk_cfg_s;

endpackage

// [hw/ocd_clock_ctrl.sv]
// Clock control register block: oscillator control, divisors, PLL feedback, RC trim
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ocd_clock_ctrl
    import ocd_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic              pslverr,
    output logic [31:0]       prdata,
    input  wire logic [2:0]   config_source,
    input  wire logic         fail_detect,
    input  wire logic         cpu_interrupt,
    input  wire logic         switch_complete,
    output logic              switch_start,
    output logic [2:0]        new_source_select,
    output logic [2:0]        current_source,
    output logic              secondary_osc_enable,
    output ocd_clk_cfg_s      clk_cfg,
    output logic              irq
);

    logic [2:0]           cur_source_reg;
    logic [2:0]           new_source_reg;
    logic                 sec_en_reg;
    logic                 sw_req_reg;
    logic                 cf_reg;
    logic                 roi_reg;
    logic [2:0]           doze_reg;
    logic                 clock_reduce_enable_reg;
    logic [2:0]           rc_postdivider_reg;
    logic [1:0]           post_reg;
    logic [4:0]           pre_reg;
    logic [8:0]           mult_reg;
    logic [5:0]           trim_reg;
    logic [1:0]           unlock_reg;
    logic [IRQ_W-1:0]     irq_status_reg;
    logic [IRQ_W-1:0]     irq_enable_reg;
    logic [2:0]           fail_sync_reg;
    logic                 fail_filt_reg;
    logic                 strap_done_reg;
    logic                 start_reg;
    ocd_sw_e              sw_state_reg;
    ocd_clk_cfg_s         clk_cfg_reg;

    logic                 wr_en;
    logic                 rd_setup;
    logic                 mapped;
    logic                 osc_wr;
    logic                 fail_rise;
    logic                 redundant;
    logic                 illegal;
    logic                 sw_accept;
    logic                 sw_abort;
    logic                 sw_finish;
    logic [IRQ_W-1:0]     irq_events;
    logic [31:0]          rd_word;

    // APB: no wait states, write lands on the access edge
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite & ~pslverr;
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb begin
        unique case (paddr)
            ADDR_OSC_CTRL, ADDR_CLK_DIV, ADDR_PLL_FBD, ADDR_RC_TRIM,
            ADDR_UNLOCK, ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    // Unlock: key1 then key2 on back to back writes, opens one control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg <= 2'h0;
        end else if (wr_en) begin
            if (paddr == ADDR_UNLOCK && pwdata[15:0] == UNLOCK_KEY1) begin
                unlock_reg <= 2'h1;
            end else if (paddr == ADDR_UNLOCK && pwdata[15:0] == UNLOCK_KEY2
                         && unlock_reg == 2'h1) begin
                unlock_reg <= 2'h2;
            end else begin
                unlock_reg <= 2'h0;
            end
        end
    end

    assign osc_wr = wr_en && paddr == ADDR_OSC_CTRL && unlock_reg == 2'h2;

    // Monitor failure comes from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_sync_reg <= 3'h0;
            fail_filt_reg <= 1'b0;
        end else begin
            fail_sync_reg <= {fail_sync_reg[1:0], fail_detect};
            if (fail_sync_reg[1] == fail_sync_reg[2]) begin
                fail_filt_reg <= fail_sync_reg[2];
            end
        end
    end

    assign fail_rise = fail_sync_reg[1] & fail_sync_reg[2] & ~fail_filt_reg;

    // Current source comes from straps, caught once after power-on release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_reg <= 1'b0;
            cur_source_reg <= RST_SRC;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            cur_source_reg <= config_source;
        end else if (sw_finish) begin
            cur_source_reg <= new_source_reg;
        end
    end

    assign redundant = new_source_reg == cur_source_reg;
    assign illegal = (new_source_reg == SRC_PRI_PLL && cur_source_reg == SRC_FRC_PLL) ||
                     (new_source_reg == SRC_FRC_PLL && cur_source_reg == SRC_PRI_PLL);

    assign sw_accept = sw_state_reg == SW_IDLE && sw_req_reg && strap_done_reg
                       && !redundant && !illegal;
    assign sw_abort  = sw_state_reg == SW_IDLE && sw_req_reg && strap_done_reg
                       && (redundant || illegal);
    assign sw_finish = sw_state_reg == SW_WAIT && switch_complete;

    // Switch sequencer handshake with the clock hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_state_reg <= SW_IDLE;
            start_reg    <= 1'b0;
        end else begin
            start_reg <= sw_accept;
            unique case (sw_state_reg)
                SW_IDLE: begin
                    if (sw_accept) begin
                        sw_state_reg <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (switch_complete) begin
                        sw_state_reg <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // Oscillator control; power-on reset is the only reset seen here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_source_reg <= RST_SRC;
            sec_en_reg     <= 1'b0;
            sw_req_reg     <= 1'b0;
        end else begin
            if (osc_wr) begin
                new_source_reg <= pwdata[OSC_NEW_LSB +: 3];
                sec_en_reg     <= pwdata[OSC_SEC_BIT];
            end
            if (sw_finish || sw_abort) begin
                sw_req_reg <= 1'b0;
            end else if (osc_wr && pwdata[OSC_SW_BIT] && sw_state_reg == SW_IDLE) begin
                sw_req_reg <= 1'b1;
            end
        end
    end

    // Clock fail flag: set beats software clear and switch clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cf_reg <= 1'b0;
        end else if (fail_rise) begin
            cf_reg <= 1'b1;
        end else if ((osc_wr && !pwdata[OSC_CF_BIT]) || sw_accept) begin
            cf_reg <= 1'b0;
        end
    end

    // Clock divisor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            roi_reg    <= 1'b0;
            doze_reg   <= RST_DOZE;
            clock_reduce_enable_reg  <= 1'b0;
            rc_postdivider_reg <= 3'h0;
            post_reg   <= RST_POST;
            pre_reg    <= 5'h00;
        end else begin
            if (wr_en && paddr == ADDR_CLK_DIV) begin
                roi_reg    <= pwdata[DIV_ROI_BIT];
                doze_reg   <= pwdata[DIV_DOZE_LSB +: 3];
                rc_postdivider_reg <= pwdata[DIV_FRC_LSB +: 3];
                post_reg   <= pwdata[DIV_POST_LSB +: 2];
                pre_reg    <= pwdata[DIV_PRE_LSB +: 5];
            end
            // Interrupt recovery wins over a software set in the same cycle
            if (cpu_interrupt && roi_reg) begin
                clock_reduce_enable_reg <= 1'b0;
            end else if (wr_en && paddr == ADDR_CLK_DIV) begin
                clock_reduce_enable_reg <= pwdata[DIV_DZEN_BIT];
            end
        end
    end

    // Feedback and trim
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_reg <= RST_MULT;
            trim_reg <= 6'h00;
        end else begin
            if (wr_en && paddr == ADDR_PLL_FBD) begin
                mult_reg <= pwdata[8:0];
            end
            if (wr_en && paddr == ADDR_RC_TRIM) begin
                trim_reg <= pwdata[5:0];
            end
        end
    end

    // Decoded clock configuration, registered for glitch-free use downstream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_cfg_reg <= '0;
        end else begin
            clk_cfg_reg.periph_log2  <= clock_reduce_enable_reg ? doze_reg : 3'h0;
            clk_cfg_reg.rc_post_log2 <= rc_postdivider_reg;
            unique case (post_reg)
                POST_DIV2: clk_cfg_reg.post_div <= 4'h2;
                POST_DIV8: clk_cfg_reg.post_div <= 4'h8;
                // Reserved code behaves as divide by four
                default:   clk_cfg_reg.post_div <= 4'h4;
            endcase
            clk_cfg_reg.pre_div <= {1'b0, pre_reg} + PRE_OFFSET;
            clk_cfg_reg.mult    <= {1'b0, mult_reg} + MULT_OFFSET;
            clk_cfg_reg.rc_trim <= trim_reg;
        end
    end

    // Interrupt status, set beats clear
    assign irq_events[IRQ_FAIL_BIT]  = fail_rise;
    assign irq_events[IRQ_DONE_BIT]  = sw_finish;
    assign irq_events[IRQ_ABORT_BIT] = sw_abort;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
            irq_enable_reg <= '0;
        end else begin
            if (wr_en && paddr == ADDR_IRQ_ENABLE) begin
                irq_enable_reg <= pwdata[IRQ_W-1:0];
            end
            if (wr_en && paddr == ADDR_IRQ_CLEAR) begin
                irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
            end else begin
                irq_status_reg <= irq_status_reg | irq_events;
            end
        end
    end

    // Read mux; unimplemented bits stay zero
    always_comb begin
        rd_word = 32'h0;
        unique case (paddr)
            ADDR_OSC_CTRL: begin
                rd_word[OSC_CUR_LSB +: 3] = cur_source_reg;
                rd_word[OSC_NEW_LSB +: 3] = new_source_reg;
                rd_word[OSC_CF_BIT]       = cf_reg;
                rd_word[OSC_SEC_BIT]      = sec_en_reg;
                rd_word[OSC_SW_BIT]       = sw_req_reg;
            end
            ADDR_CLK_DIV: begin
                rd_word[DIV_ROI_BIT]       = roi_reg;
                rd_word[DIV_DOZE_LSB +: 3] = doze_reg;
                rd_word[DIV_DZEN_BIT]      = clock_reduce_enable_reg;
                rd_word[DIV_FRC_LSB +: 3]  = rc_postdivider_reg;
                rd_word[DIV_POST_LSB +: 2] = post_reg;
                rd_word[DIV_PRE_LSB +: 5]  = pre_reg;
            end
            ADDR_PLL_FBD:    rd_word[8:0]       = mult_reg;
            ADDR_RC_TRIM:    rd_word[5:0]       = trim_reg;
            ADDR_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_reg;
            ADDR_IRQ_ENABLE: rd_word[IRQ_W-1:0] = irq_enable_reg;
            default:         rd_word = 32'h0;
        endcase
    end

    // Read data captured in the setup cycle so it comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            prdata <= rd_word;
        end
    end

    assign switch_start         = start_reg;
    assign new_source_select    = new_source_reg;
    assign current_source       = cur_source_reg;
    assign secondary_osc_enable = sec_en_reg;
    assign clk_cfg              = clk_cfg_reg;
    assign irq                  = |(irq_status_reg & irq_enable_reg);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access edges are never adjacent; three apart leaves no room for a third write
    sequence s_unlocked;
        wr_en && paddr == ADDR_UNLOCK && pwdata[15:0] == UNLOCK_KEY1
        ##3 wr_en && paddr == ADDR_UNLOCK && pwdata[15:0] == UNLOCK_KEY2;
    endsequence

    sequence s_switch_req;
        sw_state_reg == SW_IDLE && sw_req_reg && strap_done_reg;
    endsequence

    chk_fail_sets_flag: assert property (fail_rise |=> cf_reg)
        else $error("clock fail flag not set");
    chk_sec_osc_follow: assert property (osc_wr |=> secondary_osc_enable == $past(pwdata[1]))
        else $error("secondary oscillator enable wrong");
    chk_locked_write: assert property (wr_en && paddr == ADDR_OSC_CTRL && unlock_reg != 2'h2
        |=> $stable(new_source_reg))
        else $error("locked control write changed state");
    chk_unlock_opens: assert property (s_unlocked |-> ##1 (unlock_reg == 2'h2))
        else $error("unlock sequence did not open");
    chk_no_pll_cross: assert property (s_switch_req ##0 illegal |=> !sw_req_reg
        && sw_state_reg == SW_IDLE)
        else $error("illegal switch not refused");
    chk_roi_recover: assert property (cpu_interrupt && roi_reg |=> !clock_reduce_enable_reg
        ##1 clk_cfg.periph_log2 == 3'h0)
        else $error("recover on interrupt failed");
    chk_roi_off_keep: assert property (cpu_interrupt && !roi_reg && !wr_en |=> $stable(clock_reduce_enable_reg))
        else $error("interrupt changed reduction enable");
    chk_redundant_abort: assert property (s_switch_req ##0 redundant |=> !sw_req_reg
        ##0 irq_status_reg[IRQ_ABORT_BIT])
        else $error("redundant switch not aborted");
    chk_switch_finish: assert property (sw_finish |=> current_source == $past(new_source_reg)
        && !sw_req_reg)
        else $error("switch completion not applied");
    chk_switch_start: assert property (sw_accept |=> switch_start ##1 !switch_start)
        else $error("switch start pulse wrong");
    chk_cf_on_switch: assert property (sw_accept && !fail_rise |=> !cf_reg)
        else $error("clock fail flag kept over a valid switch");

    // Decoded configuration trails its registers by one edge
    chk_periph_unity: assert property (!clock_reduce_enable_reg |=> clk_cfg.periph_log2 == 3'h0)
        else $error("reduction ratio not one to one");
    chk_post_div2: assert property (post_reg == POST_DIV2 |=> clk_cfg.post_div == 4'h2)
        else $error("postscaler code zero not divide by two");
    chk_post_div8: assert property (post_reg == POST_DIV8 |=> clk_cfg.post_div == 4'h8)
        else $error("postscaler code three not divide by eight");
    chk_pre_default: assert property (pre_reg == 5'h00 |=> clk_cfg.pre_div == 6'h02)
        else $error("prescaler zero not divide by two");
    chk_mult_default: assert property (mult_reg == RST_MULT |=> clk_cfg.mult == 10'h032)
        else $error("default feedback not fifty");
    chk_trim_follow: assert property (wr_en && paddr == ADDR_RC_TRIM
        |=> ##1 clk_cfg.rc_trim == $past(pwdata[5:0], 2))
        else $error("trim value not passed on");

    // Unimplemented bits read zero whatever was written
    chk_div_gap_zero: assert property (rd_setup && paddr == ADDR_CLK_DIV |=> !prdata[5])
        else $error("clock divisor bit five not zero");
    chk_fbd_high_zero: assert property (rd_setup && paddr == ADDR_PLL_FBD
        |=> prdata[31:9] == 23'h0)
        else $error("feedback upper bits not zero");
    chk_trim_high_zero: assert property (rd_setup && paddr == ADDR_RC_TRIM
        |=> prdata[31:6] == 26'h0)
        else $error("trim upper bits not zero");
    chk_osc_gap_zero: assert property (rd_setup && paddr == ADDR_OSC_CTRL
        |=> prdata[2] == 1'b0)
        else $error("oscillator control bit two not zero");

endmodule

// [bench/tb_oscillator_pll_divider_control.sv]
// Self-checking bench for the clock control register block
`timescale 1ns/1ps
module tb_oscillator_pll_divider_control;
    import ocd_pkg::*;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [2:0]   config_source;
    logic         fail_detect;
    logic         cpu_interrupt;
    logic         switch_complete;
    logic         switch_start;
    logic [2:0]   new_source_select;
    logic [2:0]   current_source;
    logic         secondary_osc_enable;
    ocd_clk_cfg_s clk_cfg;
    logic         irq;
    int           err_total = 0;
    int           tests_run = 0;
    int           cycles = 0;
    integer       seed;
    logic [65:0]  rd_q[$];
    logic [65:0]  note;
    logic [31:0]  d;
    logic [31:0]  m;
    logic [31:0]  t;

    ocd_clock_ctrl i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .config_source(config_source), .fail_detect(fail_detect),
        .cpu_interrupt(cpu_interrupt), .switch_complete(switch_complete),
        .switch_start(switch_start), .new_source_select(new_source_select),
        .current_source(current_source), .secondary_osc_enable(secondary_osc_enable),
        .clk_cfg(clk_cfg), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (rd_q.size() != 0)
            err_total++;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Request held until pready is seen high, released only after that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic wr_osc(input logic [31:0] wd);
        wr(ADDR_UNLOCK, {16'h0, UNLOCK_KEY1});
        wr(ADDR_UNLOCK, {16'h0, UNLOCK_KEY2});
        wr(ADDR_OSC_CTRL, wd);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp,
                      input logic [32:0] mask = 33'h1ffffffff);
        rd_q.push_back({mask, exp});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse_intr;
        @(posedge pclk);
        cpu_interrupt <= 1'b1;
        @(posedge pclk);
        cpu_interrupt <= 1'b0;
    endtask

    task automatic switch_to(input logic [2:0] src, input logic ok);
        int n;
        n = 0;
        wr_osc({20'h0, 1'b0, src, 8'h00});
        // The write lands on the edge the task returns at; look once it has settled
        @(negedge pclk);
        check("new_source", {30'h0, new_source_select}, {30'h0, src});
        wr_osc({20'h0, 1'b0, src, 8'h01});
        if (ok) begin
            // Pulse is one cycle wide, so poll between rising edges
            while (switch_start !== 1'b1 && n < 20) begin
                @(negedge pclk);
                n++;
            end
            check("switch_start", {32'h0, switch_start}, 33'h1);
            @(posedge pclk);
            switch_complete <= 1'b1;
            @(posedge pclk);
            switch_complete <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [31:0] cfg_of(input logic [15:0] dv, input logic [8:0] mv,
                                           input logic [5:0] tv);
        logic [3:0] pd;
        pd = (dv[7:6] == 2'h3) ? 4'h8 : ((dv[7:6] == 2'h0) ? 4'h2 : 4'h4);
        return {dv[11] ? dv[14:12] : 3'h0, dv[10:8], pd, {1'b0, dv[4:0]} + 6'h02,
                {1'b0, mv} + 10'h002, tv};
    endfunction

    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            note = rd_q.pop_front();
            check("apb_read", {pslverr, prdata} & note[65:33], note[32:0]);
        end
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            complete_run;
        end
    end

    initial begin
        seed = 32'hceba7ca7;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fail_detect, cpu_interrupt, switch_complete} = '0;
        config_source = 3'h0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_OSC_CTRL, 33'h0);
        rd(ADDR_CLK_DIV, 33'h3040);
        rd(ADDR_PLL_FBD, 33'h0030);
        rd(ADDR_RC_TRIM, 33'h0);
        rd(8'h20, 33'h100000000, 33'h100000000);
        check("clk_cfg", {1'b0, clk_cfg}, {1'b0, cfg_of(16'h3040, 9'h030, 6'h0)});
        wr(ADDR_OSC_CTRL, 32'h6);
        rd(ADDR_OSC_CTRL, 33'h0);
        wr_osc(32'h0076);
        rd(ADDR_OSC_CTRL, 33'h2);
        check("sec_osc", {32'h0, secondary_osc_enable}, 33'h1);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            m = $random(seed);
            t = $random(seed);
            d[7:6] = i[1:0];
            d[11] = i[0];
            wr(ADDR_CLK_DIV, d);
            wr(ADDR_PLL_FBD, m);
            wr(ADDR_RC_TRIM, t);
            rd(ADDR_CLK_DIV, {17'h0, d[15:0] & 16'hffdf});
            rd(ADDR_PLL_FBD, {24'h0, m[8:0]});
            rd(ADDR_RC_TRIM, {27'h0, t[5:0]});
            check("clk_cfg", {1'b0, clk_cfg}, {1'b0, cfg_of(d[15:0], m[8:0], t[5:0])});
        end
        wr(ADDR_CLK_DIV, 32'hd800);
        pulse_intr;
        rd(ADDR_CLK_DIV, 33'hd000);
        check("periph", {30'h0, clk_cfg.periph_log2}, 33'h0);
        wr(ADDR_CLK_DIV, 32'h5800);
        pulse_intr;
        rd(ADDR_CLK_DIV, 33'h5800);
        check("periph", {30'h0, clk_cfg.periph_log2}, 33'h5);
        wr(ADDR_IRQ_ENABLE, 32'h7);
        switch_to(3'h2, 1'b1);
        rd(ADDR_OSC_CTRL, 33'h2200);
        check("current_source", {30'h0, current_source}, 33'h2);
        check("sec_osc", {32'h0, secondary_osc_enable}, 33'h0);
        check("irq", {32'h0, irq}, 33'h1);
        rd(ADDR_IRQ_STATUS, 33'h2);
        wr(ADDR_IRQ_CLEAR, 32'h2);
        rd(ADDR_IRQ_STATUS, 33'h0);
        check("irq", {32'h0, irq}, 33'h0);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        switch_to(3'h2, 1'b0);
        rd(ADDR_OSC_CTRL, 33'h2200);
        rd(ADDR_IRQ_STATUS, 33'h4);
        check("irq_masked", {32'h0, irq}, 33'h0);
        wr(ADDR_IRQ_CLEAR, 32'h4);
        switch_to(3'h3, 1'b1);
        switch_to(3'h1, 1'b0);
        rd(ADDR_OSC_CTRL, 33'h3100);
        check("current_source", {30'h0, current_source}, 33'h3);
        rd(ADDR_IRQ_STATUS, 33'h6);
        fail_detect <= 1'b1;
        repeat (6) @(posedge pclk);
        fail_detect <= 1'b0;
        rd(ADDR_OSC_CTRL, 33'h3108);
        rd(ADDR_IRQ_STATUS, 33'h7);
        wr_osc(32'h0300);
        rd(ADDR_OSC_CTRL, 33'h3300);
        repeat (2) @(posedge pclk);
        complete_run;
    end
endmodule
